// ### design/vfd_display_ctrl.sv
// Display end: receives bytes on the serial link, interprets commands,
// keeps a sixteen-position buffer and scans it onto digit outputs.
// Assumes the link pins are asynchronous to sys_clk.
//
// Decided for this implementation: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module vfd_display_ctrl #(
  parameter int STEP_CYC = vfd_pkg::STEP_CYC
) (
  input  wire logic                        sys_clk,
  input  wire logic                        rst,
  vfd_link_if.device                       link,
  output logic [vfd_pkg::NPOS-1:0]         digitEn,
  output logic [vfd_pkg::CODE_W-1:0]       glyphCode,
  output logic                             pointOn,
  output logic                             commaOn,
  output logic [vfd_pkg::BYTE_W-1:0]       lastByte,
  output logic                             byteStrobe,
  output logic [4:0]                       dutyLevel
);
  import vfd_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0] sclkSync;
  logic [1:0] dataSync;
  logic [1:0] resetSync;
  logic       sclkPrev;

  // Two stages each; only stage one reads stage zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sclkSync  <= 2'h3;
      dataSync  <= 2'h0;
      resetSync <= 2'h0;
      sclkPrev  <= 1'b1;
    end else begin
      sclkSync  <= {sclkSync[0], link.sclk};
      dataSync  <= {dataSync[0], link.sdata};
      resetSync <= {resetSync[0], link.resetN};
      sclkPrev  <= sclkSync[1];
    end
  end

  wire linkReset = rst | ~resetSync[1];
  wire sclkFall  = sclkPrev & ~sclkSync[1];

  // ----------------------------------------
  // Byte assembly
  // ----------------------------------------
  logic [6:0] shiftReg;
  logic [2:0] bitCnt;

  // Shift on each falling edge, msb arrives first
  always_ff @(posedge sys_clk) begin
    if (linkReset) begin
      shiftReg <= 7'h00;
      bitCnt   <= 3'h0;
    end else if (sclkFall) begin
      shiftReg <= {shiftReg[5:0], dataSync[1]};
      bitCnt   <= bitCnt + 3'h1;
    end
  end

  wire              byteDone = sclkFall & (bitCnt == 3'h7);
  wire [BYTE_W-1:0] rxByte   = {shiftReg, dataSync[1]};

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  wire              isCtrl = rxByte[CFLAG];
  wire              isPtr  = isCtrl & (rxByte[6:4] == CMD_PTR);
  wire              isCnt  = isCtrl & (rxByte[6:4] == CMD_CNT);
  wire              isDuty = isCtrl & (rxByte[6:5] == CMD_DUTY);
  wire [CODE_W-1:0] code   = rxByte[CODE_W-1:0];
  wire              isMark = (code == CODE_COMMA) | (code == CODE_POINT);
  wire              isChar = ~isCtrl & ~isMark;
  wire              isAttach = ~isCtrl & isMark;

  // Pointer value to buffer index, index 0 is position 1
  function automatic logic [3:0] ptr_to_index(input logic [3:0] v);
    return v + 4'h1;
  endfunction : ptr_to_index

  // ----------------------------------------
  // Control state
  // ----------------------------------------
  logic [3:0] bufPtr;
  logic [3:0] digitCnt;
  logic [4:0] duty;
  logic [3:0] lastIdx;

  // Other control nibbles fall through and change nothing
  always_ff @(posedge sys_clk) begin
    if (linkReset) begin
      bufPtr   <= PTR_RST;
      digitCnt <= CNT_RST;
      duty     <= DUTY_RST;
      lastIdx  <= 4'h0;
    end else if (byteDone) begin
      if (isPtr) begin
        bufPtr <= rxByte[3:0];
      end else if (isCnt) begin
        digitCnt <= rxByte[3:0];
      end else if (isDuty) begin
        duty <= rxByte[4:0];
      end else if (isChar) begin
        bufPtr  <= bufPtr + 4'h1;
        lastIdx <= ptr_to_index(bufPtr);
      end
    end
  end

  // ----------------------------------------
  // Display buffer
  // ----------------------------------------
  logic [CODE_W-1:0] glyphMem [NPOS];
  logic [NPOS-1:0]   pointMem;
  logic [NPOS-1:0]   commaMem;

  wire [3:0] storeIdx = ptr_to_index(bufPtr);

  // A new glyph clears the marks left by the previous one there
  always_ff @(posedge sys_clk) begin
    if (linkReset) begin
      for (int i = 0; i < NPOS; i++) begin
        glyphMem[i] <= CODE_BLANK;
      end
      pointMem <= '0;
      commaMem <= '0;
    end else if (byteDone & isChar) begin
      glyphMem[storeIdx] <= code;
      pointMem[storeIdx] <= 1'b0;
      commaMem[storeIdx] <= 1'b0;
    end else if (byteDone & isAttach) begin
      pointMem[lastIdx] <= pointMem[lastIdx] | (code == CODE_POINT);
      commaMem[lastIdx] <= commaMem[lastIdx] | (code == CODE_COMMA);
    end
  end

  // ----------------------------------------
  // Multiplex timing
  // ----------------------------------------
  logic [15:0] stepCnt;
  logic [4:0]  dutyStep;
  logic [3:0]  scanIdx;

  wire       stepEnd  = (stepCnt == 16'(STEP_CYC - 1));
  wire       slotEnd  = stepEnd & (dutyStep == DUTY_MAX - 5'h1);
  wire [3:0] scanLast = digitCnt - 4'h1; // zero wraps to fifteen

  // Each digit slot is 31 steps; scan wraps at the active count
  always_ff @(posedge sys_clk) begin
    if (linkReset) begin
      stepCnt  <= 16'h0000;
      dutyStep <= 5'h00;
      scanIdx  <= 4'h0;
    end else begin
      stepCnt <= stepEnd ? 16'h0000 : stepCnt + 16'h0001;
      if (slotEnd) begin
        dutyStep <= 5'h00;
        scanIdx  <= (scanIdx >= scanLast) ? 4'h0 : scanIdx + 4'h1;
      end else if (stepEnd) begin
        dutyStep <= dutyStep + 5'h01;
      end
    end
  end

  // Lit for duty of the 31 steps; zero duty never lights
  wire lit = (dutyStep < duty);

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  // Outputs carry the glyph code; segment decode sits downstream
  always_ff @(posedge sys_clk) begin
    if (linkReset) begin
      digitEn   <= '0;
      glyphCode <= '0;
      pointOn   <= 1'b0;
      commaOn   <= 1'b0;
    end else begin
      digitEn   <= lit ? (NPOS'(1) << scanIdx) : '0;
      glyphCode <= lit ? glyphMem[scanIdx] : '0;
      pointOn   <= lit & pointMem[scanIdx];
      commaOn   <= lit & commaMem[scanIdx];
    end
  end

  // Last received byte and its strobe, for observation
  always_ff @(posedge sys_clk) begin
    if (linkReset) begin
      lastByte   <= '0;
      byteStrobe <= 1'b0;
    end else begin
      byteStrobe <= byteDone;
      if (byteDone) begin
        lastByte <= rxByte;
      end
    end
  end

  assign dutyLevel = duty;
endmodule : vfd_display_ctrl

// ### common/vfd_pkg.sv
// Shared constants for the serial display link: timing, command codes,
// host register map and host states.
// Assumes a 100 MHz sys_clk on both ends.
package vfd_pkg;
  // ----------------------------------------
  // Clock and link timing
  // ----------------------------------------
  localparam int CLK_NS      = 10;
  localparam int SCLK_MIN_NS = 1000;   // Least shift clock high or low width
  localparam int WAIT_NS     = 40000;  // Least idle between bytes
  localparam int BB_NS       = 120000; // Least last-bit to last-bit time
  localparam int RST_NS      = 100000; // Least link reset pulse
  localparam int RD_NS       = 100000; // Least reset release to first byte
  localparam int SCLK_CYC    = (SCLK_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAIT_CYC    = (WAIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int BB_CYC      = (BB_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_CYC     = (RST_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_CYC      = (RD_NS + CLK_NS - 1) / CLK_NS;
  localparam int STEP_CYC    = 4;      // Cycles per luminance step
  // ----------------------------------------
  // Byte layout and commands
  // ----------------------------------------
  localparam int BYTE_W = 8;
  localparam int NPOS   = 16;
  localparam int CODE_W = 6;
  localparam int CFLAG  = 7;
  localparam logic [2:0] CMD_PTR  = 3'h2;
  localparam logic [2:0] CMD_CNT  = 3'h4;
  localparam logic [1:0] CMD_DUTY = 2'h3;
  localparam logic [4:0] DUTY_RST = 5'h00;
  localparam logic [4:0] DUTY_MAX = 5'h1F;
  localparam logic [3:0] PTR_RST  = 4'hF;  // Pointer value of position 1
  localparam logic [3:0] CNT_RST  = 4'h0;  // Zero means all sixteen
  localparam logic [5:0] CODE_BLANK = 6'h20;
  localparam logic [5:0] CODE_COMMA = 6'h2C;
  localparam logic [5:0] CODE_POINT = 6'h2E;
  // ----------------------------------------
  // Host register map
  // ----------------------------------------
  localparam logic [7:0] REG_DATA   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CTRL   = 8'h08;
  localparam int ST_BUSY    = 0;
  localparam int ST_RESET   = 1;
  localparam int CTRL_RESET = 0;
  localparam logic [1:0] HRESP_OKAY = 2'h0;
  typedef enum logic [2:0] {H_RST, H_RD, H_IDLE, H_HIGH, H_LOW, H_GAP} host_state_t;
endpackage : vfd_pkg

// ### common/vfd_link_if.sv
// Three-wire one-way serial display link.
// All wires are driven by the host end only.
`timescale 1ns/1ns
interface vfd_link_if;
  logic sclk;    // Shift clock, idles high
  logic sdata;   // Serial data, msb first
  logic resetN;  // Device reset, active low
  modport host   (output sclk, output sdata, output resetN);
  modport device (input sclk, input sdata, input resetN);
endinterface : vfd_link_if

// ### design/vfd_host_ctrl.sv
// Host end: an AHB-Lite slave with three registers that drives the
// serial display link, its reset pulse and the byte spacing.
// Assumes one AHB master on sys_clk; the link clock is made here.
`timescale 1ns/1ns
module vfd_host_ctrl #(
  parameter int RST_CYC = vfd_pkg::RST_CYC,
  parameter int RD_CYC  = vfd_pkg::RD_CYC,
  parameter int GAP_CYC = vfd_pkg::BB_CYC,
  parameter int BIT_CYC = vfd_pkg::SCLK_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [1:0]       hresp,
  output logic [31:0]      hrdata,
  vfd_link_if.host         link
);
  import vfd_pkg::*;

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  host_state_t state;
  logic        wrPend;
  logic [7:0]  addrQ;
  logic [7:0]  txByte;

  wire        busy     = (state != H_IDLE);
  wire        addrTake = hsel & hready & htrans[1];
  wire [31:0] statusWord = {30'h0, (state == H_RST) | (state == H_RD), busy};
  wire [31:0] readWord = (haddr[7:0] == REG_DATA)   ? {24'h0, txByte} :
                         (haddr[7:0] == REG_STATUS) ? statusWord : 32'h0;
  wire        dataWr   = wrPend & (addrQ == REG_DATA);
  wire        ctrlWr   = wrPend & (addrQ == REG_CTRL) & hwdata[CTRL_RESET];
  wire        sendGo   = dataWr & ~busy; // Writes while busy are dropped

  // Zero wait states; read data registered in the address phase
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wrPend <= 1'b0;
      addrQ  <= 8'h00;
      hrdata <= 32'h0;
    end else begin
      wrPend <= addrTake & hwrite;
      addrQ  <= haddr[7:0];
      if (addrTake & ~hwrite) begin
        hrdata <= readWord;
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;

  // ----------------------------------------
  // Link sequencer
  // ----------------------------------------
  logic [23:0] cnt;
  logic [2:0]  bitIdx;

  wire rstDone = (cnt == 24'(RST_CYC - 1));
  wire rdDone  = (cnt == 24'(RD_CYC - 1));
  wire gapDone = (cnt == 24'(GAP_CYC - 1));
  wire bitDone = (cnt == 24'(BIT_CYC - 1));

  // Data changes on the rising edge, the far end samples on the fall
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state       <= H_RST;
      cnt         <= 24'h0;
      bitIdx      <= 3'h0;
      txByte      <= 8'h00;
      link.sclk   <= 1'b1;
      link.sdata  <= 1'b0;
      link.resetN <= 1'b0;
    end else if (ctrlWr) begin
      state       <= H_RST;
      cnt         <= 24'h0;
      link.sclk   <= 1'b1;
      link.resetN <= 1'b0;
    end else begin
      cnt <= cnt + 24'h1;
      case (state)
        H_RST: begin
          if (rstDone) begin
            state       <= H_RD;
            cnt         <= 24'h0;
            link.resetN <= 1'b1;
          end
        end
        H_RD: begin
          if (rdDone) begin
            state <= H_IDLE;
          end
        end
        H_IDLE: begin
          cnt <= 24'h0;
          if (sendGo) begin
            state      <= H_HIGH;
            txByte     <= hwdata[7:0];
            bitIdx     <= 3'h0;
            link.sdata <= hwdata[7];
          end
        end
        H_HIGH: begin
          if (bitDone) begin
            state     <= H_LOW;
            cnt       <= 24'h0;
            link.sclk <= 1'b0;
          end
        end
        H_LOW: begin
          if (bitDone) begin
            cnt       <= 24'h0;
            link.sclk <= 1'b1;
            if (bitIdx == 3'h7) begin
              state <= H_GAP;
            end else begin
              state      <= H_HIGH;
              bitIdx     <= bitIdx + 3'h1;
              link.sdata <= txByte[3'h6 - bitIdx];
            end
          end
        end
        H_GAP: begin
          if (gapDone) begin
            state <= H_IDLE;
          end
        end
        default: begin
          state <= H_RST;
        end
      endcase
    end
  end
endmodule : vfd_host_ctrl

// ### dv/vfd_link_assertions.sv
// Concurrent checks on the three link wires between host and display end.
// Assumes a four-cycle bit time, as the bench sets it up.
`timescale 1ns/1ns
module vfd_link_assertions #(
  parameter int RST_CYC = 50,
  parameter int RD_CYC  = 50,
  parameter int GAP_CYC = 100
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic resetN
);
  // ----------------
  // Helper counters
  // ----------------
  logic [15:0] lowRun   = '0;
  logic [15:0] sinceRel = '0;
  logic [15:0] highRun  = '0;
  logic [2:0]  bitCnt   = '0;
  // Not cleared by rst, so the reset pulse length includes the rst time
  always_ff @(posedge sys_clk) begin
    if (resetN) lowRun <= 16'h0000;
    else lowRun <= lowRun + 16'h0001;
    if (!resetN) sinceRel <= 16'h0000;
    else if (sinceRel != 16'hFFFF) sinceRel <= sinceRel + 16'h0001;
  end
  // Idle high run and bit position; saturate so long idles never wrap
  always_ff @(posedge sys_clk) begin
    if (!sclk) highRun <= 16'h0000;
    else if (highRun != 16'hFFFF) highRun <= highRun + 16'h0001;
    if (rst || !resetN) bitCnt <= 3'h0;
    else if ($fell(sclk)) bitCnt <= bitCnt + 3'h1;
  end
  // ----------------
  // Link properties
  // ----------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Repetition counts are the bench's bit time written out as a number
  sclk_high_width_a: assert property ($rose(sclk) |-> sclk [*4])
    else $error("shift clock high phase too short");
  sclk_low_width_a: assert property ($fell(sclk) |-> !sclk [*4])
    else $error("shift clock low phase too short");
  data_hold_a: assert property (!sclk |-> $stable(sdata))
    else $error("data moved while shift clock low");
  bit_rhythm_a: assert property ($rose(sclk) && bitCnt != 3'h0 |-> ##[4:8] $fell(sclk))
    else $error("shift clock stalled inside a byte");
  reset_pulse_a: assert property ($rose(resetN) |-> lowRun >= 16'(RST_CYC))
    else $error("link reset pulse too short");
  idle_in_reset_a: assert property (!resetN |-> sclk)
    else $error("shift clock moved during link reset");
  ready_wait_a: assert property ($fell(sclk) |-> sinceRel >= 16'(RD_CYC))
    else $error("byte started too soon after link reset");
  byte_gap_a: assert property ($fell(sclk) && bitCnt == 3'h0 |-> highRun >= 16'(GAP_CYC))
    else $error("gap between bytes too short");
  byte_done_c: cover property ($fell(sclk) && bitCnt == 3'h7);
  reset_seen_c: cover property ($rose(resetN));
  next_byte_c: cover property ($fell(sclk) && bitCnt == 3'h0 && sinceRel > 16'(RD_CYC + GAP_CYC));
endmodule : vfd_link_assertions

// ### dv/tb.sv
// Bench: host end driven over AHB-Lite, display end on the link, checker beside.
// Assumes shortened link counts so the run stays short.
`timescale 1ns/1ns
module tb;
  import vfd_pkg::*;
  // -----------------
  // Signals and ends
  // -----------------
  logic        sys_clk, rst, hsel, hwrite, hready, hreadyout, pointOn, commaOn, byteStrobe;
  logic [31:0] haddr, hwdata, hrdata, rd, seed;
  logic [1:0]  htrans, hresp;
  logic [2:0]  hsize;
  logic [15:0] digitEn, seen, pts, cms, exPts, exCms;
  logic [7:0]  lastByte, c;
  logic [5:0]  glyphCode;
  logic [5:0]  gl [16];
  logic [5:0]  ex [16];
  logic [4:0]  dutyLevel, d;
  logic [3:0]  ptr, last, v;
  int          err_total, check_count, litCnt;
  logic [7:0]  ops [13] = '{8'h00, 8'h00, 8'h00, 8'h2E, 8'h80, 8'h00, 8'hA5, 8'h00, 8'h2C, 8'hAF, 8'h00, 8'hA0, 8'h00};
  vfd_link_if link ();
  assign hready = hreadyout;
  vfd_host_ctrl #(.RST_CYC(50), .RD_CYC(50), .GAP_CYC(100), .BIT_CYC(4)) vfd_host_ctrl_i (
    .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .link(link));
  vfd_display_ctrl #(.STEP_CYC(1)) vfd_display_ctrl_i (
    .sys_clk(sys_clk), .rst(rst), .link(link), .digitEn(digitEn), .glyphCode(glyphCode),
    .pointOn(pointOn), .commaOn(commaOn), .lastByte(lastByte), .byteStrobe(byteStrobe), .dutyLevel(dutyLevel));
  // Checker defaults already hold the shortened link counts
  vfd_link_assertions vfd_link_assertions_i (
    .sys_clk(sys_clk), .rst(rst), .sclk(link.sclk), .sdata(link.sdata), .resetN(link.resetN));
  // -----------------
  // Helpers
  // -----------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  // Point and comma codes are kept out so random bytes always advance
  function automatic logic [7:0] rchar();
    logic [7:0] b;
    b = 8'h20 + 8'(xs() % 64);
    return (b == 8'h2C || b == 8'h2E) ? 8'h41 : b;
  endfunction : rchar
  task automatic check(input string name, input logic [31:0] got, input logic [31:0] want);
    check_count++;
    if (got !== want) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, want, got);
    end
  endtask : check
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  // One single AHB transfer; waits on hready however long it takes
  task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] wd);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb
  // Busy is polled first, since a write while busy is silently dropped
  task automatic send(input logic [7:0] b);
    rd = 32'h1;
    while (rd[ST_BUSY] !== 1'b0) ahb(32'(REG_STATUS), 1'b0, 32'h0);
    ahb(32'(REG_DATA), 1'b1, 32'(b));
    for (int i = 0; i < 400; i++) begin
      @(posedge sys_clk);
      #1;
      if (byteStrobe === 1'b1) break;
    end
    check("byteStrobe", 32'(byteStrobe), 32'h1);
    check("lastByte", 32'(lastByte), 32'(b));
  endtask : send
  task automatic clr_model();
    ptr = PTR_RST;
    last = 4'h0;
    exPts = 16'h0000;
    exCms = 16'h0000;
    foreach (ex[p]) ex[p] = CODE_BLANK;
  endtask : clr_model
  // Sends a byte and tracks what the buffer should then hold
  task automatic apply(input logic [7:0] b);
    send(b);
    if (b[7:4] == 4'hA) ptr = b[3:0];
    else if (b == 8'h2E) exPts[last] = 1'b1;
    else if (b == 8'h2C) exCms[last] = 1'b1;
    else if (!b[7]) begin
      last = ptr + 4'h1;
      ex[last] = b[5:0];
      exPts[last] = 1'b0;
      exCms[last] = 1'b0;
      ptr = ptr + 4'h1;
    end
  endtask : apply
  // Watches one full scan of sixteen slots of 31 steps
  task automatic scan();
    seen = 16'h0000;
    litCnt = 0;
    repeat (31 * 16) begin
      @(posedge sys_clk);
      #1;
      seen = seen | digitEn;
      if (digitEn !== 16'h0000) litCnt++;
      for (int p = 0; p < 16; p++) if (digitEn[p] === 1'b1) begin
        gl[p] = glyphCode;
        pts[p] = pointOn;
        cms[p] = commaOn;
      end
    end
  endtask : scan
  // -----------------
  // Clock, run, watchdog
  // -----------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    #300000;
    err_total++;
    test_done();
  end
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    seed = 32'd47095;
    err_total = 0;
    check_count = 0;
    clr_model();
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    check("dutyLevel", 32'(dutyLevel), 32'(DUTY_RST));
    scan();
    check("dark digits", 32'(seen), 32'h0);
    for (int i = 0; i < 3; i++) begin
      d = (i == 2) ? DUTY_MAX : 5'(xs() % 31 + 1);
      send({3'b111, d});
      check("dutyLevel", 32'(dutyLevel), 32'(d));
      scan();
      check("lit cycles", 32'(litCnt), 32'(d) * 16);
    end
    foreach (ops[i]) begin
      c = (ops[i] == 8'h00) ? rchar() : (ops[i] == 8'hA0) ? {4'hA, 4'(xs() % 15)} : ops[i];
      apply(c);
    end
    check("dutyLevel", 32'(dutyLevel), 32'(DUTY_MAX));
    scan();
    foreach (ex[p]) check("glyph", 32'(gl[p]), 32'(ex[p]));
    check("points", 32'(pts), 32'(exPts));
    check("commas", 32'(cms), 32'(exCms));
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 4'h6 : (i == 1) ? 4'h0 : 4'(xs() % 15 + 1);
      send({4'hC, v});
      // A slot already running may lie beyond the new count
      repeat (31) @(posedge sys_clk);
      scan();
      check("digit mask", 32'(seen), (v == 4'h0) ? 32'hFFFF : ((32'h1 << v) - 32'h1));
    end
    ahb(32'(REG_CTRL), 1'b1, 32'h1);
    ahb(32'(REG_STATUS), 1'b0, 32'h0);
    check("status", rd, (32'h1 << ST_BUSY) | (32'h1 << ST_RESET));
    clr_model();
    apply(rchar());
    check("dutyLevel", 32'(dutyLevel), 32'(DUTY_RST));
    send(8'hFF);
    scan();
    check("digit mask", 32'(seen), 32'hFFFF);
    check("glyph", 32'(gl[0]), 32'(ex[0]));
    ahb(32'h10, 1'b0, 32'h0);
    check("unmapped read", rd, 32'h0);
    ahb(32'(REG_DATA), 1'b0, 32'h0);
    check("data readback", 32'(rd[7:0]), 32'hFF);
    check("hresp", 32'(hresp), 32'(HRESP_OKAY));
    test_done();
  end
endmodule : tb
